// File: mos_actuator.sv
// Actuator model integrating raise and lower commands into a travel position
`default_nettype none
module mos_actuator (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic raise_in,
    input wire logic lower_in,
    input wire logic [15:0] stroke_in,
    output logic [15:0] position_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both commands at once hold the motor, as a reversing contactor pair would
    wire logic up = tick_in && raise_in && !lower_in && position_out < stroke_in;
    wire logic dn = tick_in && lower_in && !raise_in && position_out != 16'h0000;
    // One step per sample tick; end stops clamp travel like limit switches
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            position_out <= 16'h0000;
        else if (up)
            position_out <= position_out + 16'h0001;
        else if (dn)
            position_out <= position_out - 16'h0001;
    end
endmodule // mos_actuator
`default_nettype wire

// File: mos_assertions.sv
// Concurrent checks on the ports of the manipulated output switchover block
`default_nettype none
module mos_assertions (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sample_tick_in,
    input wire logic manual_request_in,
    input wire logic block_request_in,
    input wire logic track_request_in,
    input wire logic fallback_request_in,
    input wire logic backup_mode_in,
    input wire logic [1:0] output_config_select_in,
    input wire logic [3:0] controller_type_select_in,
    input wire logic backup_current_off_in,
    input wire logic [9:0] low_split_point_in,
    input wire logic [9:0] high_split_point_in,
    input wire logic [7:0] min_pulse_length_setting_in,
    input wire logic [15:0] output_current_out,
    input wire logic raise_output_out,
    input wire logic lower_output_out,
    input wire logic manual_led_out,
    input wire logic manual_status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pls_r;
    wire logic bt = block_request_in | track_request_in;
    wire logic cfg0 = output_config_select_in == 2'h0;
    wire logic ddc = controller_type_select_in == 4'h3 || controller_type_select_in == 4'h9;
    // Raise pulse length in ticks; saturates so a stuck output cannot wrap
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in || !raise_output_out)
            pls_r <= 8'h00;
        else if (sample_tick_in && pls_r != 8'hFE)
            pls_r <= pls_r + 8'h01;
    end
    default clocking dc @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Repeat counts leave room for the two sync flops and the output register
    property p_status; manual_request_in [*6] |-> manual_status_out; endproperty
    a_status: assert property (p_status) else $error("status missed manual");
    property p_quiet;
        !(manual_request_in | fallback_request_in | bt) [*8] |->
            !manual_led_out && !manual_status_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle led or status lit");
    property p_led_on;
        (manual_request_in && !bt && !fallback_request_in) [*8] |-> manual_led_out;
    endproperty
    a_led_on: assert property (p_led_on) else $error("manual led not steady");
    property p_cur_off; !cfg0 [*6] |-> output_current_out == 16'h0000; endproperty
    a_cur_off: assert property (p_cur_off) else $error("current outside mode");
    property p_backup;
        (cfg0 && backup_current_off_in && backup_mode_in && ddc) [*8] |->
            output_current_out == 16'h0000;
    endproperty
    a_backup: assert property (p_backup) else $error("backup current on");
    property p_excl; !(raise_output_out && lower_output_out); endproperty
    a_excl: assert property (p_excl) else $error("both channels on");
    property p_dflt;
        (output_config_select_in == 2'h1 && low_split_point_in == 10'h000 &&
            high_split_point_in == 10'h3E8) [*8] |->
            !$rose(raise_output_out) && !$rose(lower_output_out);
    endproperty
    a_dflt: assert property (p_dflt) else $error("pulse with default splits");
    property p_minlen;
        $fell(raise_output_out) && output_config_select_in == 2'h2 |->
            pls_r + 8'h01 >= min_pulse_length_setting_in;
    endproperty
    a_minlen: assert property (p_minlen) else $error("step pulse too short");
    c_manual: cover property (manual_status_out && manual_led_out);
    c_step: cover property ($fell(raise_output_out) && output_config_select_in == 2'h2);
    c_cool: cover property (lower_output_out && output_config_select_in == 2'h1);
endmodule // mos_assertions
bind mos_top mos_assertions mos_assertions_inst (.*);
`default_nettype wire

// File: mos_led.v
// LED flasher producing off, steady and 10/50/90 percent flash codes
`default_nettype none
`include "mos_regs.vh"
module mos_led #(
    parameter STEP_CYCLES = 25000000
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire [2:0] code_in,
    output reg led_out
);
    // ************************************************************
    // Tenth-of-cycle divider
    // ************************************************************
    reg [31:0] div_r;
    reg [3:0] phase_r;
    reg [3:0] on_tenths;
    wire step = (div_r == STEP_CYCLES - 1);

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= 32'h0000_0000;
            phase_r <= 4'h0;
        end else if (step) begin
            div_r <= 32'h0000_0000;
            phase_r <= (phase_r == `MOS_LED_PHASES - 4'h1) ? 4'h0 : phase_r + 4'h1;
        end else begin
            div_r <= div_r + 32'h0000_0001;
        end
    end

    // ************************************************************
    // Code decode
    // ************************************************************
    always @* begin
        case (code_in)
            `MOS_LED_F10: on_tenths = `MOS_LED_ON_10;
            `MOS_LED_F50: on_tenths = `MOS_LED_ON_50;
            `MOS_LED_F90: on_tenths = `MOS_LED_ON_90;
            `MOS_LED_ON: on_tenths = `MOS_LED_PHASES;
            default: on_tenths = 4'h0;
        endcase
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_out <= 1'b0;
        end else begin
            led_out <= (phase_r < on_tenths);
        end
    end
endmodule // mos_led
`default_nettype wire

// File: mos_pwm.v
// Time-proportioning channel: on-time share of a period set by a duty value
`default_nettype none
`include "mos_regs.vh"
module mos_pwm (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire tick_in,
    input wire enable_in,
    input wire [15:0] period_in,
    input wire [9:0] duty_in,
    output reg pulse_out
);
    reg [15:0] cnt_r;
    reg [15:0] on_r;
    reg [15:0] on_nxt;
    wire [25:0] prod = period_in * duty_in;
    wire [25:0] quo = prod / {16'h0000, `MOS_MV_FULL};
    wire [15:0] min_t = period_in / `MOS_MIN_DIV;
    wire wrap = (cnt_r + 16'h0001 >= period_in);

    // ************************************************************
    // On-time per period, clipped at the one percent limits
    // ************************************************************
    always @* begin
        on_nxt = quo[15:0];
        if (on_nxt < min_t) begin
            on_nxt = 16'h0000;
        end else if (period_in - on_nxt < min_t) begin
            on_nxt = period_in;
        end
    end

    // Latching at the period start keeps a duty change from chopping a pulse
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= `MOS_CNT_RST;
            on_r <= `MOS_CNT_RST;
            pulse_out <= 1'b0;
        end else if (!enable_in || period_in == 16'h0000) begin
            cnt_r <= `MOS_CNT_RST;
            on_r <= `MOS_CNT_RST;
            pulse_out <= 1'b0;
        end else begin
            if (tick_in) begin
                if (wrap || cnt_r == 16'h0000) begin
                    cnt_r <= wrap ? 16'h0000 : 16'h0001;
                    on_r <= on_nxt;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
            pulse_out <= (cnt_r < on_r) || (on_r == period_in && on_r != 16'h0000);
        end
    end
endmodule // mos_pwm
`default_nettype wire

// File: mos_regs.vh
// Constants for the manipulated output switchover block
`ifndef MOS_REGS_VH
`define MOS_REGS_VH
// Manipulated variable in per mille, 0 to 1000
`define MOS_MV_W 10
`define MOS_MV_FULL 10'h03E8
`define MOS_MV_ZERO 10'h0000
// Output configurations
`define MOS_CFG_CURRENT 2'h0
`define MOS_CFG_TWOPOS 2'h1
`define MOS_CFG_STEP 2'h2
// Priority settings
`define MOS_PRIO_TRACK 1'b0
`define MOS_PRIO_MANUAL 1'b1
// Direct-digital controller types
`define MOS_CTYPE_DDC_A 4'h3
`define MOS_CTYPE_DDC_B 4'h9
// Current range select
`define MOS_RANGE_0_20 1'b0
`define MOS_RANGE_4_20 1'b1
// LED codes
`define MOS_LED_OFF 3'h0
`define MOS_LED_ON 3'h1
`define MOS_LED_F10 3'h2
`define MOS_LED_F50 3'h3
`define MOS_LED_F90 3'h4
// LED flash cycle in tenths and on-time tenths per code
`define MOS_LED_PHASES 4'hA
`define MOS_LED_ON_10 4'h1
`define MOS_LED_ON_50 4'h5
`define MOS_LED_ON_90 4'h9
// Timing: clock period and LED tenth step, in ns
`define MOS_CLK_NS 4
`define MOS_LED_STEP_NS 100000000
// Shortest two-position on or off time is period divided by this
`define MOS_MIN_DIV 16'h0064
// Current output in microamps
`define MOS_CUR_LIVE_UA 16'h0FA0
`define MOS_CUR_GAIN_20 16'h0014
`define MOS_CUR_GAIN_16 16'h0010
// Reset values
`define MOS_CNT_RST 16'h0000
`define MOS_POS_RST 16'h0000
`endif

// File: mos_tb.sv
// Self-checking bench for the manipulated output switchover block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tick = 1'b0;
    logic prio, fb, man, blk, trk, bk, boff, rng, rs_o, ls_o, led, stat, sat;
    logic [1:0] cfg;
    logic [3:0] ctyp;
    logic [7:0] te, ta;
    logic [9:0] va, vt, vb, vm, vf, ya, ye, eff;
    logic [15:0] per, ty, pos, cur, tgt, nr, nl, nd, samt;
    logic [31:0] rs = 32'h0000_0038;
    logic [9:0] tlo [9] = '{10'h000, 10'h3E8, 0, 0, 0, 10'h12C, 0, 10'h12C, 10'h12C};
    logic [9:0] thi [9] = '{10'h000, 10'h3E8, 0, 0, 10'h3E8, 10'h2BC, 0, 10'h2BC, 10'h2BC};
    logic [9:0] tyv [9] = '{10'h12C, 10'h12C, 10'h3E4, 10'h004, 10'h1F4, 10'h1F4, 10'h12C,
        10'h064, 10'h384};
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    mos_top #(.LED_STEP_CYCLES(4)) mos_top_inst (
        .core_clk_in(clk), .rst_n_in(rst_n), .sample_tick_in(tick),
        .automatic_value_in(va), .tracking_value_in(vt), .blocking_value_in(vb),
        .manual_value_in(vm), .fallback_value_in(vf), .manual_request_in(man),
        .block_request_in(blk), .track_request_in(trk), .fallback_request_in(fb),
        .backup_mode_in(bk), .priority_select_in(prio), .output_config_select_in(cfg),
        .controller_type_select_in(ctyp), .backup_current_off_in(boff),
        .current_range_select_in(rng), .low_split_point_in(ya), .high_split_point_in(ye),
        .cool_period_in(per), .heat_period_in(per), .positioning_time_in(ty),
        .min_pulse_length_setting_in(te), .min_pulse_pause_setting_in(ta),
        .effective_value_out(eff), .output_current_out(cur), .raise_output_out(rs_o),
        .lower_output_out(ls_o), .manual_led_out(led), .manual_status_out(stat),
        .sat_reduce_out(sat), .sat_amount_out(samt));
    mos_actuator mos_actuator_inst (.core_clk_in(clk), .rst_n_in(rst_n), .tick_in(tick),
        .raise_in(rs_o), .lower_in(ls_o), .stroke_in(ty), .position_out(pos));
    always #2 clk = ~clk;
    // Tick every other cycle keeps each pulse one cycle wide
    always @(posedge clk) begin
        #1 tick = ~tick;
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cnt(input int n);
        {nr, nl, nd} = 48'h0;
        repeat (n) begin
            cyc(1);
            nr += 16'(rs_o);
            nl += 16'(ls_o);
            nd += 16'(led);
        end
    endtask
    task automatic rst_chk();
        rst_n = 1'b0;
        cyc(3);
        chk(cur | samt, 16'h0000);
        chk(16'({eff, rs_o, ls_o, led, stat, sat}), 16'h0000);
        rst_n = 1'b1;
    endtask
    function automatic logic [9:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return 10'(rs % 1001);
    endfunction
    // Request word is priority, fallback, manual, block, track
    function automatic logic [9:0] exp_y(input logic [4:0] c, input logic [9:0] a, n, b, h, s);
        if (c[3]) return s;
        if (c[2] && (c[4] || !(c[1] | c[0]))) return h;
        return c[1] ? b : c[0] ? n : a;
    endfunction
    function automatic logic [15:0] exp_led(input logic [4:0] c);
        if (c[3]) return c[2] ? 16'h0005 : 16'h0001;
        if (!c[2]) return (c[1] | c[0]) ? 16'h0001 : 16'h0000;
        if (!(c[1] | c[0])) return 16'h000A;
        return c[4] ? 16'h0009 : 16'h0005;
    endfunction
    // Cycles on within 400 ticks, a whole number of periods
    function automatic logic [15:0] exp_tp(input logic [9:0] lo, hi, y, input logic [15:0] p,
        input logic heat);
        int d, on;
        d = 0;
        if (heat && y > hi) d = (y - hi) * 1000 / (1000 - hi);
        if (!heat && y < lo) d = (lo - y) * 1000 / lo;
        on = p * d / 1000;
        if (on < p / 100) on = 0;
        if (p - on < p / 100) on = p;
        return 16'(on * 2 * (400 / p));
    endfunction
    task automatic step(input logic [9:0] y, input logic [2:0] rq);
        {fb, man, trk} = rq;
        va = y;
        {vt, vm, vf} = {3{10'h3E8}};
        // Tracking has no effect in step mode, so the automatic value still steers
        if (rq[2:1] == 2'h0) tgt = 16'(y * ty / 1000);
        cyc(1200);
        chk(16'(pos + 16'h0008 >= tgt && pos <= tgt + 16'h0008), 16'h0001);
    endtask
    initial begin
        {prio, fb, man, blk, trk, bk, boff, rng, cfg, ctyp} = 14'h0000;
        {va, vt, vb, vm, vf, ya} = 60'h0;
        ye = 10'h3E8;
        {per, ty, te, ta} = {16'h00C8, 16'h0064, 8'h03, 8'h02};
        rst_chk();
        for (int c = 0; c < 32; c++) begin
            {prio, fb, man, blk, trk} = 5'(c);
            {va, vt, vb, vm, vf} = {rnd(), rnd(), rnd(), rnd(), rnd()};
            cyc(8);
            tgt = 16'(exp_y(5'(c), va, vt, vb, vm, vf));
            chk(16'(eff), tgt);
            chk(cur, tgt * 16'h0014);
            chk(16'(stat), 16'(man));
            cnt(40);
            chk(nd, exp_led(5'(c)) * 16'h0004);
        end
        {prio, fb, man, blk, trk, rng, boff, ya, ye} = {7'h03, 10'h0C8, 10'h320};
        for (int k = 0; k < 4; k++) begin
            ctyp = (k == 1) ? 4'h9 : (k == 2) ? 4'h5 : 4'h3;
            bk = (k != 3);
            va = (k == 2) ? 10'h3E8 : (k == 3) ? 10'h000 : rnd();
            cyc(8);
            tgt = (va < ya) ? 16'(ya) : (va > ye) ? 16'(ye) : 16'(va);
            chk(cur, (k < 2) ? 16'h0000 : 16'h0FA0 + tgt * 16'h0010);
        end
        rst_chk();
        cfg = 2'h1;
        for (int k = 0; k < 9; k++) begin
            {ya, ye, va} = {tlo[k], thi[k], tyv[k]};
            per = (k == 6) ? 16'h0064 : 16'h00C8;
            cyc(800);
            cnt(800);
            chk(nr, exp_tp(ya, ye, va, per, 1'b1));
            chk(nl, exp_tp(ya, ye, va, per, 1'b0));
        end
        rst_chk();
        cfg = 2'h2;
        step(10'h258, 3'h0);
        step(10'h0C8, 3'h0);
        step(10'h258, 3'h1);
        step(10'h258, 3'h2);
        step(10'h258, 3'h4);
        test_done();
    end
endmodule // testbench
`default_nettype wire

// File: mos_top.v
// Manipulated output switchover with current, two-position and step outputs
`default_nettype none
`include "mos_regs.vh"
module mos_top #(
    parameter LED_STEP_CYCLES = `MOS_LED_STEP_NS / `MOS_CLK_NS
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire sample_tick_in,
    input wire [9:0] automatic_value_in,
    input wire [9:0] tracking_value_in,
    input wire [9:0] blocking_value_in,
    input wire [9:0] manual_value_in,
    input wire [9:0] fallback_value_in,
    input wire manual_request_in,
    input wire block_request_in,
    input wire track_request_in,
    input wire fallback_request_in,
    input wire backup_mode_in,
    input wire priority_select_in,
    input wire [1:0] output_config_select_in,
    input wire [3:0] controller_type_select_in,
    input wire backup_current_off_in,
    input wire current_range_select_in,
    input wire [9:0] low_split_point_in,
    input wire [9:0] high_split_point_in,
    input wire [15:0] cool_period_in,
    input wire [15:0] heat_period_in,
    input wire [15:0] positioning_time_in,
    input wire [7:0] min_pulse_length_setting_in,
    input wire [7:0] min_pulse_pause_setting_in,
    output reg [9:0] effective_value_out,
    output reg [15:0] output_current_out,
    output reg raise_output_out,
    output reg lower_output_out,
    output wire manual_led_out,
    output reg manual_status_out,
    output reg sat_reduce_out,
    output reg [15:0] sat_amount_out
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RAISE = 2'h1;
    localparam [1:0] ST_LOWER = 2'h2;
    localparam [1:0] ST_PAUSE = 2'h3;

    // ************************************************************
    // Pin synchronisers for the request lines
    // ************************************************************
    reg [4:0] req_meta_r;
    reg [4:0] req_sync_r;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_meta_r <= 5'h00;
            req_sync_r <= 5'h00;
        end else begin
            req_meta_r <= {backup_mode_in, fallback_request_in, manual_request_in,
                           block_request_in, track_request_in};
            req_sync_r <= req_meta_r;
        end
    end
    wire trk_raw = req_sync_r[0];
    wire blk = req_sync_r[1];
    wire man = req_sync_r[2];
    wire fbk = req_sync_r[3];
    wire bkup = req_sync_r[4];

    wire is_step = (output_config_select_in == `MOS_CFG_STEP);
    wire is_cur = (output_config_select_in == `MOS_CFG_CURRENT);
    wire is_two = (output_config_select_in == `MOS_CFG_TWOPOS);
    wire trk = trk_raw & ~is_step;

    // ************************************************************
    // Source selection and LED code
    // ************************************************************
    reg [9:0] y_nxt;
    reg [2:0] led_nxt;
    reg hold_nxt;
    reg [9:0] y_r;
    reg [2:0] led_r;
    reg hold_r;
    always @* begin
        y_nxt = automatic_value_in;
        led_nxt = `MOS_LED_OFF;
        hold_nxt = 1'b0;
        if (fbk) begin
            y_nxt = fallback_value_in;
            hold_nxt = is_step;
            led_nxt = man ? `MOS_LED_F50 : `MOS_LED_F10;
        end else if (man && priority_select_in == `MOS_PRIO_MANUAL) begin
            y_nxt = manual_value_in;
            hold_nxt = is_step;
            led_nxt = (blk | trk) ? `MOS_LED_F90 : `MOS_LED_ON;
        end else if (blk) begin
            y_nxt = blocking_value_in;
            led_nxt = man ? `MOS_LED_F50 : `MOS_LED_F10;
        end else if (trk) begin
            y_nxt = tracking_value_in;
            led_nxt = man ? `MOS_LED_F50 : `MOS_LED_F10;
        end else if (man) begin
            y_nxt = manual_value_in;
            hold_nxt = is_step;
            led_nxt = `MOS_LED_ON;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            y_r <= `MOS_MV_ZERO;
            led_r <= `MOS_LED_OFF;
            hold_r <= 1'b0;
            manual_status_out <= 1'b0;
            effective_value_out <= `MOS_MV_ZERO;
        end else begin
            y_r <= (y_nxt > `MOS_MV_FULL) ? `MOS_MV_FULL : y_nxt;
            led_r <= led_nxt;
            hold_r <= hold_nxt;
            manual_status_out <= man;
            effective_value_out <= y_r;
        end
    end

    mos_led #(
        .STEP_CYCLES(LED_STEP_CYCLES)
    ) u_led (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .code_in(led_r),
        .led_out(manual_led_out)
    );

    // ************************************************************
    // Continuous current output
    // ************************************************************
    wire [9:0] y_lim = (y_r < low_split_point_in) ? low_split_point_in :
                       (y_r > high_split_point_in) ? high_split_point_in : y_r;
    wire cur_off = backup_current_off_in & bkup &
                   (controller_type_select_in == `MOS_CTYPE_DDC_A ||
                    controller_type_select_in == `MOS_CTYPE_DDC_B);
    wire [15:0] cur_4_20 = `MOS_CUR_LIVE_UA + {6'h00, y_lim} * `MOS_CUR_GAIN_16;
    wire [15:0] cur_0_20 = {6'h00, y_lim} * `MOS_CUR_GAIN_20;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            output_current_out <= 16'h0000;
        end else if (!is_cur || cur_off) begin
            output_current_out <= 16'h0000;
        end else if (current_range_select_in == `MOS_RANGE_4_20) begin
            output_current_out <= cur_4_20;
        end else begin
            output_current_out <= cur_0_20;
        end
    end

    // ************************************************************
    // Two-position split into cooling and heating sections
    // ************************************************************
    // A split point at 0 or 1000 leaves one section empty, so a single channel results
    wire cool_en = is_two && (y_r < low_split_point_in);
    wire heat_en = is_two && (y_r > high_split_point_in);
    wire [9:0] cool_den = (low_split_point_in == 10'h000) ? 10'h001 : low_split_point_in;
    wire [9:0] heat_span = `MOS_MV_FULL - high_split_point_in;
    wire [9:0] heat_den = (heat_span == 10'h000) ? 10'h001 : heat_span;
    wire [19:0] cool_num = (low_split_point_in - y_r) * `MOS_MV_FULL;
    wire [19:0] heat_num = (y_r - high_split_point_in) * `MOS_MV_FULL;
    wire [19:0] cool_q = cool_num / {10'h000, cool_den};
    wire [19:0] heat_q = heat_num / {10'h000, heat_den};
    wire cool_pulse;
    wire heat_pulse;

    mos_pwm u_cool (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tick_in(sample_tick_in),
        .enable_in(cool_en),
        .period_in(cool_period_in),
        .duty_in(cool_q[9:0]),
        .pulse_out(cool_pulse)
    );

    mos_pwm u_heat (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tick_in(sample_tick_in),
        .enable_in(heat_en),
        .period_in(heat_period_in),
        .duty_in(heat_q[9:0]),
        .pulse_out(heat_pulse)
    );

    // ************************************************************
    // Three-position step output with simulated actuator
    // ************************************************************
    // Travel is counted in sample ticks: full stroke equals positioning time
    reg [1:0] st_r;
    reg [15:0] pos_r;
    reg [15:0] tgt_r;
    reg [15:0] cnt_r;
    wire [25:0] tgt_prod = {6'h00, y_r} * {10'h000, positioning_time_in};
    wire [25:0] tgt_q = tgt_prod / {16'h0000, `MOS_MV_FULL};
    wire [15:0] tgt_raw = tgt_q[15:0];
    wire signed [16:0] err = $signed({1'b0, tgt_r}) - $signed({1'b0, pos_r});
    wire signed [16:0] on_thr = $signed({8'h00, min_pulse_length_setting_in, 1'b0});
    wire signed [16:0] off_thr = $signed({9'h000, min_pulse_length_setting_in});
    wire [15:0] te = {8'h00, min_pulse_length_setting_in};
    wire [15:0] ta = {8'h00, min_pulse_pause_setting_in};
    wire at_top = (pos_r >= positioning_time_in);
    wire at_bot = (pos_r == 16'h0000);
    wire pulse_done = (cnt_r + 16'h0001 >= te);

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;
            pos_r <= `MOS_POS_RST;
            tgt_r <= `MOS_POS_RST;
            cnt_r <= `MOS_CNT_RST;
            sat_reduce_out <= 1'b0;
            sat_amount_out <= 16'h0000;
        end else if (!is_step) begin
            st_r <= ST_IDLE;
            cnt_r <= `MOS_CNT_RST;
            sat_reduce_out <= 1'b0;
        end else begin
            sat_reduce_out <= 1'b0;
            if (sample_tick_in) begin
                // Target creeps one travel tick per sample tick at most, except that hold_r snaps it to pos_r
                if (!hold_r && tgt_r < tgt_raw) begin
                    tgt_r <= tgt_r + 16'h0001;
                end else if (!hold_r && tgt_r > tgt_raw) begin
                    tgt_r <= tgt_r - 16'h0001;
                end else if (hold_r) begin
                    tgt_r <= pos_r;
                end
                case (st_r)
                    ST_IDLE: begin
                        cnt_r <= `MOS_CNT_RST;
                        if (err >= on_thr && on_thr != 17'sh0_0000) begin
                            st_r <= ST_RAISE;
                        end else if (err <= -on_thr && on_thr != 17'sh0_0000) begin
                            st_r <= ST_LOWER;
                        end
                    end
                    ST_RAISE: begin
                        cnt_r <= cnt_r + 16'h0001;
                        if (!at_top) begin
                            pos_r <= pos_r + 16'h0001;
                        end else if (tgt_r > pos_r) begin
                            // Integrator and PID output back off by the same excess
                            tgt_r <= pos_r;
                            sat_amount_out <= tgt_r - pos_r;
                            sat_reduce_out <= 1'b1;
                        end
                        if (pulse_done && (err <= off_thr || at_top)) begin
                            st_r <= ST_PAUSE;
                            cnt_r <= `MOS_CNT_RST;
                        end
                    end
                    ST_LOWER: begin
                        cnt_r <= cnt_r + 16'h0001;
                        if (!at_bot) begin
                            pos_r <= pos_r - 16'h0001;
                        end else if (tgt_r < pos_r) begin
                            tgt_r <= pos_r;
                        end
                        if (pulse_done && (err >= -off_thr || at_bot)) begin
                            st_r <= ST_PAUSE;
                            cnt_r <= `MOS_CNT_RST;
                        end
                    end
                    ST_PAUSE: begin
                        cnt_r <= cnt_r + 16'h0001;
                        if (cnt_r + 16'h0001 >= ta) begin
                            st_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Output form select
    // ************************************************************
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            raise_output_out <= 1'b0;
            lower_output_out <= 1'b0;
        end else begin
            case (output_config_select_in)
                `MOS_CFG_TWOPOS: begin
                    raise_output_out <= heat_pulse;
                    lower_output_out <= cool_pulse;
                end
                `MOS_CFG_STEP: begin
                    raise_output_out <= (st_r == ST_RAISE);
                    lower_output_out <= (st_r == ST_LOWER);
                end
                default: begin
                    raise_output_out <= 1'b0;
                    lower_output_out <= 1'b0;
                end
            endcase
        end
    end
endmodule // mos_top
`default_nettype wire
